// ==== rtl/airr_regs.v ====
`timescale 1ns/1ps
`include "airr_map.vh"
// two routing registers and the common-mode register for the first right input, plus applied gain outputs
module airr_regs (
	input  wire       i_clock,
	input  wire       i_rst,
	input  wire [7:0] i_addr,
	input  wire       i_wr_en,
	input  wire [7:0] i_wr_data,
	input  wire       i_fs_tick,
	output reg  [7:0] o_rd_data,
	output wire       o_left_diff,
	output wire       o_left_connect,
	output wire [3:0] o_left_level,
	output wire       o_right_diff,
	output wire       o_right_connect,
	output wire [3:0] o_right_level,
	output wire       o_right_adc_power,
	output wire       o_right_cm_tie
);
	// mixer paths fed by the first right input: index 0 is the left mixer, index 1 the right one
	localparam NPATH = 2;
	// width of an input level code
	localparam LW    = 4;

	// stored fields; reserved bits have no flops behind them, so they cannot drift from their fixed value
	reg           l_diff_r;
	reg           l_diff_nxt;
	reg  [LW-1:0] l_lvl_r;
	reg  [LW-1:0] l_lvl_nxt;
	reg           r_diff_r;
	reg           r_diff_nxt;
	reg  [LW-1:0] r_lvl_r;
	reg  [LW-1:0] r_lvl_nxt;
	reg           r_pwr_r;
	reg           r_pwr_nxt;
	reg  [1:0]    r_step_r;
	reg  [1:0]    r_step_nxt;
	reg           cm_en_r;
	reg           cm_en_nxt;
	reg  [7:0]    rd_nxt;

	// write strobes, one per register
	wire          wr_l;
	wire          wr_r;
	wire          wr_cm;

	// per-path views handed to the generate loop
	wire [LW-1:0] tgt_path [0:NPATH-1];
	wire [LW-1:0] lvl_path [0:NPATH-1];
	wire          con_path [0:NPATH-1];

	// a level code connects only when it lies in the valid gain table
	function connects;
		input [LW-1:0] code;
		begin
			connects = (code <= `AIRR_LVL_MAX);
		end
	endfunction

	// address match shared by the write strobes and the read mux
	function hit;
		input [7:0] addr;
		input [7:0] want;
		begin
			hit = (addr == want);
		end
	endfunction

	// level field of a written byte; both routing registers keep it in the same place
	function [LW-1:0] lvl_of;
		input [7:0] data;
		begin
			lvl_of = data[`AIRR_LVL_HI:`AIRR_LVL_LO];
		end
	endfunction

	// a write lands at the edge where the strobe is seen; unmapped addresses are dropped
	assign wr_l  = i_wr_en & hit(i_addr, `AIRR_ADDR_L);
	assign wr_r  = i_wr_en & hit(i_addr, `AIRR_ADDR_R);
	assign wr_cm = i_wr_en & hit(i_addr, `AIRR_ADDR_CM);

	// left routing register: configuration and level follow the written byte
	// the low three bits of the byte are thrown away, which keeps them reading zero
	always @* begin
		l_diff_nxt = l_diff_r;
		l_lvl_nxt  = l_lvl_r;
		if (wr_l) begin
			l_diff_nxt = i_wr_data[`AIRR_BIT_DIFF];
			l_lvl_nxt  = lvl_of(i_wr_data);
		end
	end

	// reset leaves the input single-ended and disconnected from the left mixer
	always @(posedge i_clock) begin
		if (i_rst) begin
			l_diff_r <= `AIRR_RST_BIT;
			l_lvl_r  <= `AIRR_LVL_OFF;
		end else begin
			l_diff_r <= l_diff_nxt;
			l_lvl_r  <= l_lvl_nxt;
		end
	end

	// right routing register: configuration, level, power and stepping rate
	always @* begin
		r_diff_nxt = r_diff_r;
		r_lvl_nxt  = r_lvl_r;
		r_pwr_nxt  = r_pwr_r;
		r_step_nxt = r_step_r;
		if (wr_r) begin
			r_diff_nxt = i_wr_data[`AIRR_BIT_DIFF];
			r_lvl_nxt  = lvl_of(i_wr_data);
			r_pwr_nxt  = i_wr_data[`AIRR_BIT_PWR];
			r_step_nxt = i_wr_data[`AIRR_STEP_HI:`AIRR_STEP_LO];
		end
	end

	// reset powers the right channel down and picks stepping once per sample
	always @(posedge i_clock) begin
		if (i_rst) begin
			r_diff_r <= `AIRR_RST_BIT;
			r_lvl_r  <= `AIRR_LVL_OFF;
			r_pwr_r  <= `AIRR_RST_BIT;
			r_step_r <= `AIRR_RST_STEP;
		end else begin
			r_diff_r <= r_diff_nxt;
			r_lvl_r  <= r_lvl_nxt;
			r_pwr_r  <= r_pwr_nxt;
			r_step_r <= r_step_nxt;
		end
	end

	// common-mode register: only the tie enable is stored
	// the reserved fields are not stored, so a careless write cannot corrupt them
	always @* begin
		cm_en_nxt = cm_en_r;
		if (wr_cm)
			cm_en_nxt = i_wr_data[`AIRR_BIT_CMEN];
	end

	// tie to the common-mode node starts disabled
	always @(posedge i_clock) begin
		if (i_rst)
			cm_en_r <= `AIRR_RST_BIT;
		else
			cm_en_r <= cm_en_nxt;
	end

	// read image of the addressed register; unmapped addresses read zero
	always @* begin
		rd_nxt = 8'h00;
		if (hit(i_addr, `AIRR_ADDR_L))
			rd_nxt = {l_diff_r, l_lvl_r, `AIRR_ZERO3};
		else if (hit(i_addr, `AIRR_ADDR_R))
			rd_nxt = {r_diff_r, r_lvl_r, r_pwr_r, r_step_r};
		else if (hit(i_addr, `AIRR_ADDR_CM))
			rd_nxt = {`AIRR_CM_RSVD_HI, cm_en_r, `AIRR_ZERO2};
	end

	// read data is registered, so it answers one edge after the address is seen
	always @(posedge i_clock) begin
		if (i_rst)
			o_rd_data <= 8'h00;
		else
			o_rd_data <= rd_nxt;
	end

	// programmed targets of the two mixer paths
	assign tgt_path[0] = l_lvl_r;
	assign tgt_path[1] = r_lvl_r;

	// one stepper per path; both share the right register's rate because the left rate field
	// lives outside this block, so a left-only rate change cannot be expressed here
	genvar p;
	generate
		for (p = 0; p < NPATH; p = p + 1) begin : g_path
			airr_stepper #(.W(LW)) u_step (
				.i_clock  (i_clock),
				.i_rst    (i_rst),
				.i_target (tgt_path[p]),
				.i_rate   (r_step_r),
				.i_fs_tick(i_fs_tick),
				.o_level  (lvl_path[p])
			);
			// reserved codes never connect; software is trusted to avoid them
			assign con_path[p] = connects(lvl_path[p]);
		end
	endgenerate

	// applied levels and connections leave per path
	assign o_left_level      = lvl_path[0];
	assign o_right_level     = lvl_path[1];
	assign o_left_connect    = con_path[0];
	assign o_right_connect   = con_path[1];

	// static switch controls come straight from their flops
	assign o_left_diff       = l_diff_r;
	assign o_right_diff      = r_diff_r;
	assign o_right_adc_power = r_pwr_r;
	assign o_right_cm_tie    = cm_en_r;
endmodule // airr_regs

// ==== rtl/airr_map.vh ====
// Contract
// - bit 7 of the right-input-to-left-ADC register picks single-ended (0) or differential (1), reset 0.
// - bits 6..3 of the right-input-to-left-ADC register hold an attenuation code, 0 to 8 giving 0 dB to -12 dB and connecting.
// - attenuation code 1111 disconnects the input from the left mixer and is the reset value.
// - bits 2..0 of the right-input-to-left-ADC register are read-only zeros, reset 000.
// - the right-ADC register has its own level field in bits 6..3 with the same codes, reset 1111.
// - bit 7 of the right-ADC register picks single-ended or differential on the right path, reset 0.
// - bit 2 of the right-ADC register powers the right ADC up when 1, reset 0.
// - bits 1..0 of the right-ADC register set soft-stepping: 00 every sample, 01 every two, 1x off, reset 00.
// - bit 2 of the common-mode register ties unselected right inputs to the common-mode node, reset 0.
// - bits 7..3 of the common-mode register are reserved with value 01111.
// - bits 1..0 of the common-mode register are reserved with value 00.
`ifndef AIRR_MAP_VH
`define AIRR_MAP_VH
`define AIRR_ADDR_L        8'h15
`define AIRR_ADDR_R        8'h16
`define AIRR_ADDR_CM       8'h17
`define AIRR_BIT_DIFF      7
`define AIRR_LVL_HI        6
`define AIRR_LVL_LO        3
`define AIRR_BIT_PWR       2
`define AIRR_STEP_HI       1
`define AIRR_STEP_LO       0
`define AIRR_BIT_CMEN      2
`define AIRR_LVL_OFF       4'hf
`define AIRR_LVL_MAX       4'h8
`define AIRR_CM_RSVD_HI    5'h0f
`define AIRR_STEP_EVERY1   2'h0
`define AIRR_STEP_EVERY2   2'h1
`define AIRR_RST_BIT       1'h0
`define AIRR_RST_STEP      2'h0
`define AIRR_ZERO3         3'h0
`define AIRR_ZERO2         2'h0
`endif

// ==== rtl/airr_stepper.v ====
`timescale 1ns/1ps
`include "airr_map.vh"
// applied level tracks the programmed target, one code per stepping interval; connect, disconnect and stepping off act at once
module airr_stepper #(
	parameter W = 4
) (
	input  wire         i_clock,
	input  wire         i_rst,
	input  wire [W-1:0] i_target,
	input  wire [1:0]   i_rate,
	input  wire         i_fs_tick,
	output reg  [W-1:0] o_level
);
	reg  half_r;
	wire step_on  = (i_rate == `AIRR_STEP_EVERY1) | (i_rate == `AIRR_STEP_EVERY2);
	wire step_now = i_fs_tick & ((i_rate == `AIRR_STEP_EVERY1) | half_r);
	wire off_move = (i_target == `AIRR_LVL_OFF) | (o_level == `AIRR_LVL_OFF);

	// connect and disconnect are switch events, so they act at once rather than stepping
	always @(posedge i_clock) begin
		if (i_rst) begin
			o_level <= `AIRR_LVL_OFF;
			half_r  <= 1'b0;
		end else begin
			if (i_fs_tick)
				half_r <= ~half_r;
			if (!step_on || off_move)
				o_level <= i_target;
			else if (step_now && o_level < i_target)
				o_level <= o_level + {{(W-1){1'b0}}, 1'b1};
			else if (step_now && o_level > i_target)
				o_level <= o_level - {{(W-1){1'b0}}, 1'b1};
		end
	end
endmodule // airr_stepper

// ==== test/airr_regs_assertions.sv ====
`timescale 1ns/1ps
// register writes must show at the switch control outputs one edge later
module airr_regs_chk (
	input wire       i_clock,
	input wire       i_rst,
	input wire [7:0] i_addr,
	input wire       i_wr_en,
	input wire [7:0] i_wr_data,
	input wire [7:0] o_rd_data,
	input wire       o_left_diff,
	input wire       o_left_connect,
	input wire [3:0] o_left_level,
	input wire       o_right_diff,
	input wire       o_right_connect,
	input wire [3:0] o_right_level,
	input wire       o_right_adc_power,
	input wire       o_right_cm_tie
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	property p_ldiff; i_wr_en && i_addr == 8'h15 |=> o_left_diff == $past(i_wr_data[7]); endproperty
	a_ldiff: assert property (p_ldiff) else $error("left config bit wrong");
	property p_rdiff; i_wr_en && i_addr == 8'h16 |=> o_right_diff == $past(i_wr_data[7]); endproperty
	a_rdiff: assert property (p_rdiff) else $error("right config bit wrong");
	property p_pwr; i_wr_en && i_addr == 8'h16 |=> o_right_adc_power == $past(i_wr_data[2]); endproperty
	a_pwr: assert property (p_pwr) else $error("power bit wrong");
	property p_cm; i_wr_en && i_addr == 8'h17 |=> o_right_cm_tie == $past(i_wr_data[2]); endproperty
	a_cm: assert property (p_cm) else $error("tie bit wrong");
	property p_rd15; i_addr == 8'h15 |=> o_rd_data[2:0] == 3'h0; endproperty
	a_rd15: assert property (p_rd15) else $error("reserved bits not zero");
	property p_rd17; i_addr == 8'h17 |=> o_rd_data[7:3] == 5'h0f && o_rd_data[1:0] == 2'h0; endproperty
	a_rd17: assert property (p_rd17) else $error("reserved pattern wrong");
	property p_lcon; o_left_connect == (o_left_level <= 4'h8); endproperty
	a_lcon: assert property (p_lcon) else $error("left connect wrong");
	property p_rcon; o_right_connect == (o_right_level <= 4'h8); endproperty
	a_rcon: assert property (p_rcon) else $error("right connect wrong");
	c_step: cover property (o_right_connect ##1 $changed(o_right_level));
	c_pwr: cover property (i_wr_en && i_addr == 8'h16 && i_wr_data[2]);
	c_lcon: cover property ($rose(o_left_connect));
endmodule // airr_regs_chk
bind airr_regs airr_regs_chk u_airr_regs_chk (.*);

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	reg        i_clock = 0, i_rst = 1, i_wr_en = 0, i_fs_tick = 0;
	reg  [7:0] i_addr = 8'h00, i_wr_data = 8'h00, s [0:2];
	wire [7:0] o_rd_data;
	wire [3:0] o_left_level, o_right_level;
	wire       o_left_diff, o_left_connect, o_right_diff, o_right_connect, o_right_adc_power, o_right_cm_tie;
	integer    miscompares = 0, samples_checked = 0, k;
	reg  [7:0] ra;
	reg [31:0] rng = 32'h5a;
	airr_regs u_airr_regs (.*);
	initial forever #10 i_clock = ~i_clock;
	// hang guard, far beyond the few hundred cycles used
	initial begin #400000 miscompares = miscompares + 1; summarize; end
	function [31:0] xs(input [31:0] x);
		xs = x ^ (x << 13);
		xs = xs ^ (xs >> 17);
		xs = xs ^ (xs << 5);
	endfunction
	// readback image: reserved bits always read their fixed value
	function [7:0] ex(input [7:0] a, input [7:0] d);
		ex = a == 8'h15 ? d & 8'hf8 : a == 8'h16 ? d : a == 8'h17 ? {5'h0f, d[2], 2'h0} : 8'h00;
	endfunction
	// software rules: no reserved codes, fixed reserved bits, one configuration on both paths
	function [7:0] legal(input [7:0] a, input [7:0] d);
		legal = d;
		if (d[6:3] > 4'h8 && d[6:3] != 4'hf) legal[6:3] = 4'hf;
		if (a == 8'h15) legal[2:0] = 3'h0;
		if (a == 8'h17) legal = {5'h0f, d[2], 2'h0};
		if (a == 8'h15 && s[1][6:3] != 4'hf) legal[7] = s[1][7];
		if (a == 8'h16 && s[0][6:3] != 4'hf) legal[7] = s[0][7];
	endfunction
	task summarize; begin
		$display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
		if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	end endtask
	task ck(input [7:0] g, input [7:0] e); begin
		samples_checked = samples_checked + 1;
		if (g !== e) begin
			miscompares = miscompares + 1;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	end endtask
	task wr(input [7:0] a, input [7:0] d); begin
		@(posedge i_clock) #1 {i_addr, i_wr_data, i_wr_en} = {a, d, 1'b1};
		@(posedge i_clock) #1 i_wr_en = 0;
		if (a < 8'h18) s[a - 8'h15] = ex(a, d);
	end endtask
	task rd(input [7:0] a); begin
		@(posedge i_clock) #1 i_addr = a;
		@(posedge i_clock) #1 ck(o_rd_data, a > 8'h17 ? 8'h00 : s[a - 8'h15]);
	end endtask
	task tick; begin
		@(posedge i_clock) #1 i_fs_tick = 1;
		@(posedge i_clock) #1 i_fs_tick = 0;
	end endtask
	// reset values, random writes with masking, then soft-step timing
	initial begin
		for (k = 0; k < 3; k = k + 1) s[k] = 8'h78;
		repeat (10) @(posedge i_clock);
		#1 i_rst = 0;
		for (k = 8'h15; k < 8'h19; k = k + 1) rd(k);
		ck({o_left_level, o_right_level}, 8'hff);
		for (k = 0; k < 40; k = k + 1) begin
			rng = xs(rng);
			ra = 8'h15 + rng[9:8];
			wr(ra, legal(ra, rng[7:0]));
			rd(ra);
			ck({o_left_diff, o_right_diff, o_right_adc_power, o_right_cm_tie}, {s[0][7], s[1][7], s[1][2], s[2][2]});
		end
		wr(8'h15, 8'h78);
		wr(8'h16, 8'h7b);
		wr(8'h16, 8'h00);
		@(posedge i_clock) #1;
		ck({o_right_connect, o_right_level}, 8'h10);
		wr(8'h16, 8'h20);
		for (k = 1; k < 5; k = k + 1) begin
			tick;
			ck(o_right_level, k);
		end
		wr(8'h16, 8'h41);
		repeat (2) tick;
		ck(o_right_level, 8'h05);
		wr(8'h16, 8'h92);
		rd(8'h16);
		ck(o_right_level, 8'h02);
		wr(8'h15, 8'h80);
		@(posedge i_clock) #1;
		ck({o_left_diff, o_left_connect, o_left_level}, 8'h30);
		wr(8'h15, 8'h78);
		@(posedge i_clock) #1;
		ck({o_left_connect, o_left_level}, 8'h0f);
		summarize;
	end
endmodule // tb_top
